// ---- rtl/cba_bus_access.sv ----
// CPU internal bus access: state set, bus cycle timing, block move, interrupt stacking.
// Assumes on-chip memory answers within its cycle and peripherals flag slow access.
`timescale 1ns/10ps
module cba_bus_access
   import cba_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic [2:0]  exec_mode_sel,
   input  wire logic        halt_req,
   input  wire logic [4:0]  halt_mode_sel,
   input  wire logic        wake_req,
   input  wire logic        irq_req,
   input  wire logic [15:0] pc_value,
   input  wire logic [7:0]  cond_code_value,
   input  wire logic [15:0] stack_pointer_register,
   output logic             sp_update_valid,
   output logic [15:0]      sp_update,
   output logic [3:0]       cpu_state,
   output logic [4:0]       halt_mode,
   output logic             exc_done,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic        req_word,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             rsp_valid,
   output logic [15:0]      rsp_data,
   input  wire logic        move_start,
   input  wire logic [7:0]  move_count_register,
   input  wire logic [15:0] move_source_pointer,
   input  wire logic [15:0] move_destination_pointer,
   output logic             move_busy,
   output logic             move_done,
   output logic [7:0]       move_count_out,
   output logic [15:0]      move_src_out,
   output logic [15:0]      move_dst_out,
   output logic             mem_en,
   output logic             mem_we,
   output logic             mem_word,
   output logic [15:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata,
   output logic             per_en,
   output logic             per_we,
   output logic [15:0]      per_addr,
   output logic [7:0]       per_wdata,
   input  wire logic [7:0]  per_rdata,
   input  wire logic        per_slow
);
   typedef struct packed {
      cba_cpu_state_t  cpu;
      cba_halt_mode_t  halt;
      cba_bus_state_t  bus;
      cba_move_state_t mv;
      cba_region_t     region;
      cba_owner_t      owner;
      logic [3:0]      sub_cnt;
      logic [1:0]      cnt;
      logic [1:0]      len;
      logic            write;
      logic            word;
      logic [15:0]     addr;
      logic            exc_irq;
      logic [1:0]      push_left;
      logic [15:0]     sp;
      logic            sp_valid;
      logic            exc_done;
      logic            rsp_valid;
      logic [15:0]     rsp_data;
      logic [7:0]      mv_cnt;
      logic [15:0]     mv_src;
      logic [15:0]     mv_dst;
      logic [7:0]      mv_byte;
      logic            mv_done;
      logic            mem_en;
      logic            mem_we;
      logic            mem_word;
      logic [15:0]     mem_addr;
      logic [15:0]     mem_wdata;
      logic            per_en;
      logic            per_we;
      logic [15:0]     per_addr;
      logic [7:0]      per_wdata;
   } cba_state_t;

   cba_state_t         s_reg;
   cba_state_t         s_next;
   logic               state_en;
   logic               fifo_valid;
   logic               fifo_pop;
   logic [FIFO_W-1:0]  fifo_data;
   logic               st_go;
   cba_owner_t         st_owner;
   logic               st_write;
   logic               st_word;
   logic [15:0]        st_addr;
   logic [15:0]        st_data;
   cba_region_t        st_region;
   logic [15:0]        rd_data;
   logic [7:0]         mem_byte;

   // Address decode; the vector area belongs to the ROM range
   function automatic cba_region_t decode(input logic [15:0] a);
      if (a <= ROM_HI) decode = RG_ROM;
      else if (a >= IO_A_LO && a <= IO_A_HI) decode = RG_IO_A;
      else if (a >= RAM_LO && a <= RAM_HI) decode = RG_RAM;
      else if (a >= IO_B_LO) decode = RG_IO_B;
      else decode = RG_NONE;
   endfunction

   cba_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_req_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   ({req_write, req_word, req_addr, req_wdata}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // One state per system clock edge, or per subclock tick while executing in subactive mode
   assign state_en = (s_reg.cpu == CPU_EXEC && exec_mode_sel == EX_SUB) ?
                     (s_reg.sub_cnt == 4'h0) : 1'b1;

   // Bus arbitration: stacking first, then block move, then queued requests
   always_comb begin
      st_go    = 1'b0;
      st_owner = OWN_REQ;
      st_write = 1'b0;
      st_word  = 1'b0;
      st_addr  = 16'h0000;
      st_data  = 16'h0000;
      fifo_pop = 1'b0;
      if (state_en && s_reg.bus == BUS_IDLE) begin
         if (s_reg.cpu == CPU_EXCEPT && s_reg.push_left != 2'h0) begin
            st_go    = 1'b1;
            st_owner = OWN_PUSH;
            st_write = 1'b1;
            st_word  = 1'b1;
            st_addr  = s_reg.sp - PUSH_STEP;
            st_data  = (s_reg.push_left == 2'h2) ? pc_value
                       : {cond_code_value, cond_code_value};
         end else if (s_reg.cpu == CPU_EXEC && s_reg.mv == MV_READ) begin
            st_go    = 1'b1;
            st_owner = OWN_MRD;
            st_addr  = s_reg.mv_src;
         end else if (s_reg.cpu == CPU_EXEC && s_reg.mv == MV_WRITE) begin
            st_go    = 1'b1;
            st_owner = OWN_MWR;
            st_write = 1'b1;
            st_addr  = s_reg.mv_dst;
            st_data  = {s_reg.mv_byte, s_reg.mv_byte};
         end else if (s_reg.cpu == CPU_EXEC && s_reg.mv == MV_IDLE && fifo_valid) begin
            st_go    = 1'b1;
            fifo_pop = 1'b1;
            st_write = fifo_data[33];
            st_word  = fifo_data[32];
            st_addr  = fifo_data[31:16];
            st_data  = fifo_data[15:0];
         end
      end
   end

   assign st_region = decode(st_addr);
   assign mem_byte  = s_reg.addr[0] ? mem_rdata[7:0] : mem_rdata[15:8];

   // Read data as seen by the CPU at the end of a cycle
   always_comb begin
      case (s_reg.region)
         RG_ROM, RG_RAM: rd_data = s_reg.word ? mem_rdata : {8'h00, mem_byte};
         RG_IO_A, RG_IO_B: rd_data = s_reg.word ? {per_rdata, UNDEF_BYTE}
                                    : {8'h00, per_rdata};
         RG_NONE: rd_data = s_reg.word ? {UNDEF_BYTE, UNDEF_BYTE}
                            : {8'h00, UNDEF_BYTE};
         default: rd_data = 16'h0000;
      endcase
   end

   always_comb begin
      s_next           = s_reg;
      s_next.sp_valid  = 1'b0;
      s_next.exc_done  = 1'b0;
      s_next.rsp_valid = 1'b0;
      s_next.mv_done   = 1'b0;
      s_next.sub_cnt   = (s_reg.sub_cnt == SUB_DIV - 4'h1) ? 4'h0 : s_reg.sub_cnt + 4'h1;

      case (s_reg.cpu)
         CPU_RESET: begin
            s_next.cpu       = CPU_EXCEPT;
            s_next.exc_irq   = 1'b0;
            s_next.push_left = 2'h0;
         end
         CPU_EXEC: begin
            if (s_reg.bus == BUS_IDLE && s_reg.mv == MV_IDLE && !st_go) begin
               if (irq_req) begin
                  s_next.cpu       = CPU_EXCEPT;
                  s_next.exc_irq   = 1'b1;
                  s_next.push_left = 2'h2;
                  s_next.sp        = stack_pointer_register;
               end else if (halt_req) begin
                  s_next.cpu  = CPU_HALT;
                  s_next.halt = cba_halt_mode_t'(halt_mode_sel);
               end
            end
         end
         CPU_HALT: begin
            if (wake_req || irq_req) begin
               s_next.cpu = CPU_EXEC;
            end
         end
         CPU_EXCEPT: begin
            if (s_reg.push_left == 2'h0 && s_reg.bus == BUS_IDLE) begin
               s_next.cpu      = CPU_EXEC;
               s_next.exc_done = 1'b1;
               s_next.sp_valid = s_reg.exc_irq;
            end
         end
         default: s_next.cpu = CPU_RESET;
      endcase

      // Block move start; a zero count finishes at once
      if (move_start && s_reg.mv == MV_IDLE && s_reg.cpu == CPU_EXEC) begin
         s_next.mv_cnt = move_count_register;
         s_next.mv_src = move_source_pointer;
         s_next.mv_dst = move_destination_pointer;
         if (move_count_register == 8'h00) begin
            s_next.mv_done = 1'b1;
         end else begin
            s_next.mv = MV_READ;
         end
      end

      case (s_reg.bus)
         BUS_IDLE: begin
            if (st_go) begin
               s_next.bus    = BUS_RUN;
               s_next.cnt    = 2'h1;
               s_next.owner  = st_owner;
               s_next.region = st_region;
               s_next.write  = st_write;
               s_next.word   = st_word;
               s_next.addr   = st_addr;
               if (st_owner == OWN_PUSH) begin
                  s_next.sp        = st_addr;
                  s_next.push_left = s_reg.push_left - 2'h1;
               end
               case (st_region)
                  RG_ROM, RG_RAM: begin
                     s_next.len       = LEN_MEM;
                     s_next.mem_en    = 1'b1;
                     s_next.mem_we    = st_write;
                     s_next.mem_word  = st_word;
                     s_next.mem_addr  = st_addr;
                     s_next.mem_wdata = st_word ? st_data : {st_data[7:0], st_data[7:0]};
                  end
                  RG_IO_A, RG_IO_B: begin
                     s_next.len = (st_region == RG_IO_A) ? LEN_SLOW
                                  : LEN_FAST;
                     s_next.per_en    = 1'b1;
                     s_next.per_we    = st_write;
                     s_next.per_addr  = st_addr;
                     s_next.per_wdata = st_word ? st_data[15:8] : st_data[7:0];
                  end
                  default: begin
                     s_next.len = LEN_FAST;
                  end
               endcase
            end
         end
         BUS_RUN: begin
            if (state_en) begin
               if (s_reg.cnt == s_reg.len) begin
                  s_next.bus    = BUS_IDLE;
                  s_next.mem_en = 1'b0;
                  s_next.mem_we = 1'b0;
                  s_next.per_en = 1'b0;
                  s_next.per_we = 1'b0;
                  case (s_reg.owner)
                     OWN_REQ: begin
                        s_next.rsp_valid = 1'b1;
                        s_next.rsp_data  = s_reg.write ? 16'h0000 : rd_data;
                     end
                     OWN_MRD: begin
                        s_next.mv_byte = rd_data[7:0];
                        s_next.mv      = MV_WRITE;
                     end
                     OWN_MWR: begin
                        s_next.mv_src = s_reg.mv_src + 16'h0001;
                        s_next.mv_dst = s_reg.mv_dst + 16'h0001;
                        s_next.mv_cnt = s_reg.mv_cnt - 8'h01;
                        if (s_reg.mv_cnt == 8'h01) begin
                           s_next.mv      = MV_IDLE;
                           s_next.mv_done = 1'b1;
                        end else begin
                           s_next.mv = MV_READ;
                        end
                     end
                     default: begin
                     end
                  endcase
               end else begin
                  s_next.cnt = s_reg.cnt + 2'h1;
                  // Slow flag is only meaningful once the address is on the bus
                  if (s_reg.region == RG_IO_B && per_slow) begin
                     s_next.len = LEN_SLOW;
                  end
               end
            end
         end
         default: s_next.bus = BUS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_reg        <= '0;
         s_reg.cpu    <= CPU_RESET;
         s_reg.halt   <= HL_SLEEP_HIGH;
         s_reg.bus    <= BUS_IDLE;
         s_reg.mv     <= MV_IDLE;
         s_reg.region <= RG_NONE;
         s_reg.owner  <= OWN_REQ;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cpu_state       = s_reg.cpu;
   assign halt_mode       = s_reg.halt;
   assign exc_done        = s_reg.exc_done;
   assign sp_update_valid = s_reg.sp_valid;
   assign sp_update       = s_reg.sp;
   assign rsp_valid       = s_reg.rsp_valid;
   assign rsp_data        = s_reg.rsp_data;
   assign move_busy       = (s_reg.mv != MV_IDLE);
   assign move_done       = s_reg.mv_done;
   assign move_count_out  = s_reg.mv_cnt;
   assign move_src_out    = s_reg.mv_src;
   assign move_dst_out    = s_reg.mv_dst;
   assign mem_en          = s_reg.mem_en;
   assign mem_we          = s_reg.mem_we;
   assign mem_word        = s_reg.mem_word;
   assign mem_addr        = s_reg.mem_addr;
   assign mem_wdata       = s_reg.mem_wdata;
   assign per_en          = s_reg.per_en;
   assign per_we          = s_reg.per_we;
   assign per_addr        = s_reg.per_addr;
   assign per_wdata       = s_reg.per_wdata;

   // Checking helpers: states seen while a strobe is up
   logic [2:0] ticks_reg;
   always_ff @(posedge ref_clk) begin
      if (reset || !(mem_en || per_en)) begin
         ticks_reg <= 3'h0;
      end else if (state_en) begin
         ticks_reg <= ticks_reg + 3'h1;
      end
   end

   sequence seq_io_word_write;
      $rose(per_en) && per_we && s_reg.word;
   endsequence

   sequence seq_cycle_end;
      s_reg.bus == BUS_RUN && state_en && s_reg.cnt == s_reg.len;
   endsequence

   a_mem_two_states: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(mem_en) |-> ticks_reg == 3'h2)
      else $error("memory cycle not two states");
   a_io_low_three: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(per_en) && $past(s_reg.region) == RG_IO_A |-> ticks_reg == 3'h3)
      else $error("low I/O cycle not three states");
   a_io_high_len: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(per_en) |-> ticks_reg == 3'h2 || ticks_reg == 3'h3)
      else $error("peripheral cycle length wrong");
   a_empty_quiet: assert property (@(posedge ref_clk) disable iff (reset)
      s_reg.bus == BUS_RUN && s_reg.region == RG_NONE |-> !mem_en && !per_en)
      else $error("strobe raised for unassigned area");
   a_io_word_upper: assert property (@(posedge ref_clk) disable iff (reset)
      seq_io_word_write |-> per_wdata == s_reg.per_wdata && $past(st_data[15:8]) == per_wdata)
      else $error("peripheral word write not upper byte");
   a_io_word_read: assert property (@(posedge ref_clk) disable iff (reset)
      seq_cycle_end and (s_reg.owner == OWN_REQ && !s_reg.write && s_reg.word
      && s_reg.region == RG_IO_B) |=> rsp_valid && rsp_data == {$past(per_rdata), UNDEF_BYTE})
      else $error("peripheral word read wrong");
   a_cpu_onehot: assert property (@(posedge ref_clk) disable iff (reset)
      $onehot(cpu_state))
      else $error("cpu state not one of four");
   a_zero_move: assert property (@(posedge ref_clk) disable iff (reset)
      move_start && move_count_register == 8'h00 && !move_busy && cpu_state == CPU_EXEC
      |=> move_done && !move_busy ##1 !mem_en[*2])
      else $error("zero count move did a transfer");
   a_move_step: assert property (@(posedge ref_clk) disable iff (reset)
      seq_cycle_end and s_reg.owner == OWN_MWR
      |=> move_count_out == $past(move_count_out) - 8'h01
      && move_dst_out == $past(move_dst_out) + 16'h0001)
      else $error("move pointers or count not stepped");
   a_halt_no_bus: assert property (@(posedge ref_clk) disable iff (reset)
      cpu_state == CPU_HALT |-> s_reg.bus == BUS_IDLE && !mem_en && !per_en)
      else $error("bus active in halt");
   a_push_done: assert property (@(posedge ref_clk) disable iff (reset)
      sp_update_valid |-> cpu_state == CPU_EXEC && $past(cpu_state) == CPU_EXCEPT)
      else $error("stack update outside exception exit");
   a_sub_rate: assert property (@(posedge ref_clk) disable iff (reset)
      cpu_state == CPU_EXEC && exec_mode_sel == EX_SUB && state_en |=> !state_en)
      else $error("subclock states too close");
endmodule // cba_bus_access

// ---- rtl/cba_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module cba_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 count;
   } cba_fifo_state_t;

   cba_fifo_state_t s_reg;
   cba_fifo_state_t s_next;
   logic            push;
   logic            pop;

   assign in_ready  = (s_reg.count != DEPTH[AW:0]);
   assign out_valid = (s_reg.count != '0);
   assign out_data  = s_reg.mem[s_reg.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wp] = in_data;
         s_next.wp            = s_reg.wp + 1'b1;
      end
      if (pop) begin
         s_next.rp = s_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         s_next.count = s_reg.count + 1'b1;
      end else if (pop && !push) begin
         s_next.count = s_reg.count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule // cba_fifo

// ---- rtl/cba_pkg.sv ----
// Constants, state encodings and address map for the CPU internal bus access block.
// Assumes a single 100 MHz clock; the subclock CPU rate is made as enable pulses.
package cba_pkg;
   // Clock rate and the subclock state rate, kept as a divide ratio
   localparam int         CLK_PERIOD_NS = 10;
   localparam logic [3:0] SUB_DIV       = 4'h8;

   // Address map
   localparam logic [15:0] ROM_LO  = 16'h0000;
   localparam logic [15:0] ROM_HI  = 16'h7fff;
   localparam logic [15:0] IO_A_LO = 16'hf770;
   localparam logic [15:0] IO_A_HI = 16'hf77f;
   localparam logic [15:0] RAM_LO  = 16'hfb80;
   localparam logic [15:0] RAM_HI  = 16'hff7f;
   localparam logic [15:0] IO_B_LO = 16'hffa0;
   localparam logic [15:0] IO_B_HI = 16'hffff;

   // Bus cycle lengths in states
   localparam logic [1:0] LEN_MEM  = 2'h2;
   localparam logic [1:0] LEN_FAST = 2'h2;
   localparam logic [1:0] LEN_SLOW = 2'h3;

   // Value returned where the bus has nothing to give
   localparam logic [7:0]  UNDEF_BYTE = 8'hff;
   localparam logic [15:0] PUSH_STEP  = 16'h0002;

   // Request FIFO shape: write, word, address, write data
   localparam int FIFO_W = 34;
   localparam int FIFO_D = 16;

   typedef enum logic [3:0] {
      CPU_RESET  = 4'h1,
      CPU_EXEC   = 4'h2,
      CPU_HALT   = 4'h4,
      CPU_EXCEPT = 4'h8
   } cba_cpu_state_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h1,
      BUS_RUN  = 2'h2
   } cba_bus_state_t;

   typedef enum logic [2:0] {
      MV_IDLE  = 3'h1,
      MV_READ  = 3'h2,
      MV_WRITE = 3'h4
   } cba_move_state_t;

   typedef enum logic [4:0] {
      RG_ROM  = 5'h01,
      RG_RAM  = 5'h02,
      RG_IO_A = 5'h04,
      RG_IO_B = 5'h08,
      RG_NONE = 5'h10
   } cba_region_t;

   typedef enum logic [3:0] {
      OWN_REQ  = 4'h1,
      OWN_MRD  = 4'h2,
      OWN_MWR  = 4'h4,
      OWN_PUSH = 4'h8
   } cba_owner_t;

   typedef enum logic [2:0] {
      EX_HIGH = 3'h1,
      EX_MED  = 3'h2,
      EX_SUB  = 3'h4
   } cba_exec_mode_t;

   typedef enum logic [4:0] {
      HL_SLEEP_HIGH = 5'h01,
      HL_SLEEP_MED  = 5'h02,
      HL_STANDBY    = 5'h04,
      HL_WATCH      = 5'h08,
      HL_SUBSLEEP   = 5'h10
   } cba_halt_mode_t;
endpackage

// ---- verification/cba_mem_model.sv ----
// Behavioural on-chip ROM/RAM and peripheral registers at the far side of the bus.
// Assumes registered strobes from the bus block; odd high I/O addresses answer slowly.
`timescale 1ns/10ps
module cba_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        mem_en,
   input  wire logic        mem_we,
   input  wire logic        mem_word,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic      [15:0] mem_rdata,
   input  wire logic        per_en,
   input  wire logic        per_we,
   input  wire logic [15:0] per_addr,
   input  wire logic [7:0]  per_wdata,
   output logic      [7:0]  per_rdata,
   output logic             per_slow
);
   logic [15:0] ram [0:255];
   logic [7:0]  io  [0:255];
   logic [15:0] junk = 16'h5a3c;
   // Unselected buses show a changing pattern, never the last value
   assign mem_rdata = mem_en ? ram[mem_addr[8:1]] : junk;
   assign per_rdata = per_en ? io[per_addr[7:0]] : junk[7:0];
   assign per_slow  = per_addr[0];
   always @(posedge ref_clk) begin
      junk <= junk + 16'h1357;
      if (mem_en && mem_we) begin
         if (mem_word) ram[mem_addr[8:1]] <= mem_wdata;
         else if (mem_addr[0]) ram[mem_addr[8:1]][7:0] <= mem_wdata[7:0];
         else ram[mem_addr[8:1]][15:8] <= mem_wdata[15:8];
      end
      if (per_en && per_we) io[per_addr[7:0]] <= per_wdata;
   end
endmodule // cba_mem_model

// ---- verification/tb_top.sv ----
// Self-checking bench: bus cycles, peripheral quirks, block move, halt, interrupt.
// Assumes the bus block and the memory model share port names with this bench.
`timescale 1ns/10ps
module tb_top;
   import cba_pkg::*;
   logic        ref_clk, reset, halt_req, wake_req, irq_req, req_valid, req_write, req_word;
   logic        move_start, sp_update_valid, exc_done, req_ready, rsp_valid, move_busy;
   logic        move_done, mem_en, mem_we, mem_word, per_en, per_we, per_slow;
   logic [2:0]  exec_mode_sel;
   logic [3:0]  cpu_state;
   logic [4:0]  halt_mode_sel, halt_mode;
   logic [7:0]  cond_code_value, move_count_register, per_rdata, per_wdata, move_count_out;
   logic [15:0] pc_value, stack_pointer_register, req_addr, req_wdata, sp_update, rsp_data;
   logic [15:0] move_source_pointer, move_destination_pointer, move_src_out, move_dst_out;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, per_addr, r;
   int          err_count, total_checks, n, k, i;
   cba_bus_access cba_bus_access_i (.*);
   cba_mem_model  cba_mem_model_i (.*);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One request; n counts cycles with a strobe up, r takes the answer
   task automatic xfer(input logic w, input logic wd, input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      {req_valid, req_write, req_word, req_addr, req_wdata} = {1'b1, w, wd, a, d};
      chk(req_ready, 1'b1);
      @(posedge ref_clk);
      @(negedge ref_clk);
      req_valid = 1'b0;
      n = 0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 200) begin
         @(posedge ref_clk);
         #1;
         if (mem_en === 1'b1 || per_en === 1'b1) n++;
         k++;
      end
      chk(rsp_valid, 1'b1);
      r = rsp_data;
   endtask
   task automatic t_mem;
      xfer(1, 1, 16'hfb80, 16'h1122); chk(n, 2);
      xfer(0, 0, 16'hfb81, 16'h0); chk(r, 16'h0022);
      xfer(0, 1, 16'hfb80, 16'h0); chk(r, 16'h1122);
      $display("test mem done");
   endtask
   task automatic t_io;
      xfer(1, 0, 16'hf770, 16'h005a); chk(n, 3);
      xfer(0, 0, 16'hf770, 16'h0); chk(r, 16'h005a);
      xfer(1, 1, 16'hffa0, 16'hab12); chk(n, 2);
      xfer(0, 1, 16'hffa0, 16'h0); chk(r, 16'habff);
      xfer(0, 0, 16'hffa0, 16'h0); chk(r, 16'h00ab);
      xfer(1, 0, 16'hffa1, 16'h0033); chk(n, 3);
      $display("test io done");
   endtask
   task automatic t_empty;
      xfer(1, 1, 16'h8000, 16'hbeef); chk(n, 0);
      xfer(0, 0, 16'h8000, 16'h0); chk(r, 16'h00ff);
      $display("test empty done");
   endtask
   task automatic t_move(input logic [7:0] c);
      @(negedge ref_clk);
      {move_start, move_count_register} = {1'b1, c};
      {move_source_pointer, move_destination_pointer} = {16'hfb80, 16'hfb90};
      @(negedge ref_clk);
      move_start = 1'b0;
      chk(move_busy, c != 8'h0);
      k = 0;
      while (move_done !== 1'b1 && k < 100) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      chk(move_done, 1'b1);
      if (c == 8'h0) chk(k, 0);
      chk(move_count_out, 16'h0);
      chk(move_src_out, 16'hfb80 + c);
      chk(move_dst_out, 16'hfb90 + c);
      $display("test move done");
   endtask
   task automatic t_sub;
      @(negedge ref_clk);
      exec_mode_sel = 3'h2;
      xfer(0, 1, 16'hfb80, 16'h0);
      chk(n, 2);
      @(negedge ref_clk);
      exec_mode_sel = 3'h4;
      xfer(0, 1, 16'hfb80, 16'h0);
      chk(n, 2 * SUB_DIV);
      chk(r, 16'h1122);
      @(posedge ref_clk);
      @(negedge ref_clk);
      exec_mode_sel = 3'h1;
      $display("test sub done");
   endtask
   task automatic t_halt;
      for (i = 0; i < 5; i++) begin
         @(negedge ref_clk);
         {halt_mode_sel, halt_req} = {5'h01 << i, 1'b1};
         repeat (4) @(negedge ref_clk);
         chk(cpu_state, 4'h4);
         chk(halt_mode, 5'h01 << i);
         {halt_req, wake_req} = 2'b01;
         repeat (4) @(negedge ref_clk);
         wake_req = 1'b0;
         chk(cpu_state, 4'h2);
      end
      $display("test halt done");
   endtask
   task automatic t_irq;
      @(negedge ref_clk);
      irq_req = 1'b1;
      @(negedge ref_clk);
      irq_req = 1'b0;
      k = 0;
      while (exc_done !== 1'b1 && k < 100) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      chk(exc_done, 1'b1);
      chk(sp_update_valid, 1'b1);
      chk(sp_update, 16'hfbfc);
      xfer(0, 1, 16'hfbfe, 16'h0); chk(r, 16'h1234);
      xfer(0, 1, 16'hfbfc, 16'h0); chk(r, 16'h5a5a);
      $display("test irq done");
   endtask
   initial begin
      {reset, halt_req, wake_req, irq_req, req_valid, req_write, req_word, move_start} = 8'h80;
      {exec_mode_sel, halt_mode_sel, cond_code_value, move_count_register} = {3'h1, 5'h01, 16'h5a00};
      {pc_value, stack_pointer_register, req_addr, req_wdata} = {16'h1234, 16'hfc00, 32'h0};
      {move_source_pointer, move_destination_pointer} = 32'h0;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      @(posedge ref_clk);
      #1;
      chk(cpu_state, 4'h8);
      @(posedge ref_clk);
      #1;
      chk(cpu_state, 4'h2);
      t_mem();
      t_io();
      t_empty();
      t_move(8'h2);
      xfer(0, 1, 16'hfb90, 16'h0); chk(r, 16'h1122);
      t_move(8'h0);
      t_sub();
      t_halt();
      t_irq();
      close_out();
   end
   initial begin
      #100000;
      err_count++;
      close_out();
   end
endmodule // tb_top
